// [prog_telegram_top.v]
/*
 Telegram engine: supply-line receiver, command execution,
 replies on the output pin, burn handshake and selection.
 Assumes comparator levels synchronous to clock_in; the pin
 is resolved outside.
*/
`include "prog_link_defines.vh"

module prog_telegram_top #(
    parameter [19:0] SYNC_MIN_CYCLES      =
        `US_TO_CYC(`SUPPLY_BIT_MIN_US),
    parameter [19:0] SYNC_MAX_CYCLES      =
        `US_TO_CYC(`SUPPLY_BIT_MAX_US),
    parameter [19:0] REPLY_BIT_CYCLES     = `US_TO_CYC(`REPLY_BIT_US),
    parameter [24:0] PROG_WAIT_CYCLES     =
        `US_TO_CYC(`PROG_DELAY_MAX_US + `PROG_RISE_MAX_US),
    parameter [24:0] PROG_HOLD_MIN_CYCLES =
        `US_TO_CYC(`PROG_HOLD_MIN_US),
    parameter [15:0] SELECT_MIN_CYCLES    = `US_TO_CYC(`SELECT_MIN_US),
    parameter [15:0] SELECT_MAX_CYCLES    = `US_TO_CYC(`SELECT_MAX_US)
) (
    input  wire        clock_in,
    input  wire        reset_in,
    input  wire        supply_level_in,
    input  wire        program_level_in,
    input  wire        pin_in,
    input  wire [13:0] adc_value_in,
    input  wire [3:0]  cfg_addr_in,
    output wire        pin_out,
    output wire        pin_oe_n_out,
    output wire        selected_out,
    output wire        analog_mode_out,
    output wire        burning_out,
    output wire [13:0] cfg_data_out
);
    localparam [6:0] S_IDLE  = 7'h01;
    localparam [6:0] S_HDR   = 7'h02;
    localparam [6:0] S_DAT   = 7'h04;
    localparam [6:0] S_EXEC  = 7'h08;
    localparam [6:0] S_REPLY = 7'h10;
    localparam [6:0] S_PWAIT = 7'h20;
    localparam [6:0] S_PHOLD = 7'h40;

    // Significant width of each register, zero when unmapped
    function [3:0] reg_width;
        input [3:0] a;
        begin
            case (a)
                4'h1:    reg_width = 4'd10;
                4'h2:    reg_width = 4'd11;
                4'h3:    reg_width = 4'd11;
                4'h4:    reg_width = 4'd14;
                4'h5:    reg_width = 4'd6;
                4'h6:    reg_width = 4'd1;
                4'h7:    reg_width = 4'd14;
                4'h8:    reg_width = 4'd5;
                4'h9:    reg_width = 4'd5;
                4'hb:    reg_width = 4'd6;
                4'hc:    reg_width = 4'd5;
                4'hd:    reg_width = 4'd8;
                4'hf:    reg_width = 4'd12;
                default: reg_width = 4'd0;
            endcase
        end
    endfunction

    // Registers software may write
    function writable;
        input [3:0] a;
        begin
            case (a)
                4'h1, 4'h2, 4'h3, 4'h4, 4'h5,
                4'hb, 4'hc, 4'hf: writable = 1'b1;
                default:          writable = 1'b0;
            endcase
        end
    endfunction

    // Low-bit mask of a given width
    function [13:0] low_mask;
        input [3:0] w;
        begin
            low_mask = ~(14'h3fff << w);
        end
    endfunction

    // One when the low w bits hold an odd count of zeros
    function odd_zeros;
        input [13:0] v;
        input [3:0]  w;
        begin
            odd_zeros = ^(~v & low_mask(w));
        end
    endfunction

    reg  [6:0]  st_q;
    reg  [8:0]  hdr_q;
    reg  [3:0]  hdr_cnt_q;
    reg  [14:0] dat_q;
    reg  [3:0]  dat_cnt_q;
    reg  [13:0] ram_q [0:15];
    reg  [13:0] nv_q  [0:15];
    reg         lock_q;
    reg         selected_q;
    reg  [24:0] prog_cnt_q;
    reg  [15:0] act_cnt_q;
    reg         pin_prev_q;
    reg         enc_start_q;
    reg  [4:0]  enc_count_q;
    reg  [15:0] enc_bits_q;
    reg  [13:0] cfg_data_q;
    integer     i;

    wire        frame_start;
    wire        bit_valid;
    wire        bit_value;
    wire        frame_end;
    wire        enc_busy;
    wire        enc_pin;
    wire        enc_oe_n;

    // Header fields, first received bit in the top position
    wire [8:0]  hdr_next  = {hdr_q[7:0], bit_value};
    wire [2:0]  cmd       = hdr_q[8:6];
    wire        cmd_par   = hdr_q[5];
    wire [3:0]  addr      = hdr_q[4:1];
    wire        addr_par  = hdr_q[0];
    wire [13:0] data      = dat_q[14:1];
    wire        data_par  = dat_q[0];
    wire [3:0]  width     = reg_width(addr);

    // Parity checks on the received telegram
    wire        cmd_ok    = cmd_par == odd_zeros({11'h000, cmd}, 4'd3);
    wire        addr_ok   = addr_par == odd_zeros({10'h000, addr}, 4'd4);
    wire        data_ok   = data_par == ~odd_zeros(data, 4'd14);
    wire        hdr_ok    = cmd_ok && addr_ok;

    // Read source, then left-aligned for the reply
    wire [13:0] rd_raw    = (addr == `ADDR_LOCK) ? {13'h0000, lock_q} :
                            (addr == `ADDR_ADC)  ? adc_value_in :
                            ram_q[addr];
    wire [13:0] rd_align  = rd_raw << (4'd14 - width);
    wire        rd_par    = ~odd_zeros(rd_align, 4'd14);
    wire [13:0] wr_value  = data & low_mask(width);

    wire        rd_legal  = width != 4'd0 && addr != `ADDR_DEACT;
    wire        is_deact  = addr == `ADDR_DEACT;
    wire        deact_hit = data[11:0] == `DEACT_VALUE;

    assign pin_out         = enc_pin;
    assign pin_oe_n_out    = enc_oe_n;
    assign selected_out    = selected_q;
    assign analog_mode_out = lock_q;
    assign burning_out     = st_q[6];
    assign cfg_data_out    = cfg_data_q;

    supply_bit_decoder #(
        .MIN_CYC (SYNC_MIN_CYCLES),
        .MAX_CYC (SYNC_MAX_CYCLES)
    ) u_dec (
        .clock_in        (clock_in),
        .reset_in        (reset_in),
        .line_in         (supply_level_in),
        .frame_start_out (frame_start),
        .bit_valid_out   (bit_valid),
        .bit_value_out   (bit_value),
        .frame_end_out   (frame_end)
    );

    // Reply bit period is fixed by the acknowledge bit length
    reply_bit_encoder #(
        .BIT_CYC (REPLY_BIT_CYCLES)
    ) u_enc (
        .clock_in (clock_in),
        .reset_in (reset_in),
        .start_in (enc_start_q),
        .count_in (enc_count_q),
        .bits_in  (enc_bits_q),
        .pin_out  (enc_pin),
        .oe_n_out (enc_oe_n),
        .busy_out (enc_busy)
    );

    // Telegram sequencer and command execution
    always @(posedge clock_in) begin
        enc_start_q <= 1'b0;
        cfg_data_q  <= ram_q[cfg_addr_in];
        if (reset_in) begin
            st_q        <= S_IDLE;
            hdr_q       <= 9'h000;
            hdr_cnt_q   <= 4'h0;
            dat_q       <= 15'h0000;
            dat_cnt_q   <= 4'h0;
            lock_q      <= 1'b0;
            prog_cnt_q  <= 25'h0000000;
            enc_count_q <= 5'h00;
            enc_bits_q  <= 16'h0000;
            cfg_data_q  <= 14'h0000;
            for (i = 0; i < 16; i = i + 1) begin
                ram_q[i] <= 14'h0000;
                nv_q[i]  <= 14'h0000;
            end
        end else begin
            case (st_q)
                S_IDLE: begin
                    hdr_cnt_q <= 4'h0;
                    dat_cnt_q <= 4'h0;
                    if (frame_start) st_q <= S_HDR;
                end
                S_HDR: begin
                    if (frame_end) begin
                        st_q <= S_IDLE;
                    end else if (bit_valid) begin
                        hdr_q     <= hdr_next;
                        hdr_cnt_q <= hdr_cnt_q + 4'd1;
                        if (hdr_cnt_q == `HDR_BITS - 4'd1) begin
                            st_q <= (hdr_next[8:6] == `CMD_WRITE) ?
                                    S_DAT : S_EXEC;
                        end
                    end
                end
                S_DAT: begin
                    if (frame_end) begin
                        st_q <= S_IDLE;
                    end else if (bit_valid) begin
                        dat_q     <= {dat_q[13:0], bit_value};
                        dat_cnt_q <= dat_cnt_q + 4'd1;
                        if (dat_cnt_q == 4'd14) st_q <= S_EXEC;
                    end
                end
                S_EXEC: begin
                    st_q        <= S_IDLE;
                    enc_count_q <= `REPLY_ACK;
                    enc_bits_q  <= 16'h0000;
                    if (!hdr_ok || !selected_q) begin
                        st_q <= S_IDLE;
                    end else begin
                        case (cmd)
                            `CMD_READ: begin
                                if (rd_legal) begin
                                    enc_count_q <= `REPLY_LONG;
                                    enc_bits_q  <=
                                        {1'b0, rd_align, rd_par};
                                    enc_start_q <= 1'b1;
                                    st_q        <= S_REPLY;
                                end
                            end
                            `CMD_WRITE: begin
                                if (data_ok && !lock_q &&
                                    writable(addr) && !is_deact) begin
                                    ram_q[addr] <= wr_value;
                                    enc_start_q <= 1'b1;
                                    st_q        <= S_REPLY;
                                end
                            end
                            `CMD_BURN, `CMD_ERASE: begin
                                if (!lock_q) begin
                                    enc_start_q <= 1'b1;
                                    st_q        <= S_REPLY;
                                end
                            end
                            `CMD_LOCK: begin
                                if (!lock_q) begin
                                    lock_q      <= 1'b1;
                                    enc_start_q <= 1'b1;
                                    st_q        <= S_REPLY;
                                end
                            end
                            default: st_q <= S_IDLE;
                        endcase
                    end
                end
                S_REPLY: begin
                    prog_cnt_q <= 25'h0000000;
                    if (!enc_start_q && !enc_busy) begin
                        st_q <= (cmd == `CMD_BURN || cmd == `CMD_ERASE) ?
                                S_PWAIT : S_IDLE;
                    end
                end
                S_PWAIT: begin
                    prog_cnt_q <= prog_cnt_q + 25'd1;
                    if (program_level_in) begin
                        st_q       <= S_PHOLD;
                        prog_cnt_q <= 25'h0000000;
                    end else if (prog_cnt_q >= PROG_WAIT_CYCLES) begin
                        st_q <= S_IDLE;
                    end
                end
                S_PHOLD: begin
                    if (prog_cnt_q != 25'h1ffffff) begin
                        prog_cnt_q <= prog_cnt_q + 25'd1;
                    end
                    if (!program_level_in) begin
                        st_q <= S_IDLE;
                        if (prog_cnt_q >= PROG_HOLD_MIN_CYCLES) begin
                            for (i = 0; i < 16; i = i + 1) begin
                                nv_q[i] <= (cmd == `CMD_BURN) ?
                                    ram_q[i] : 14'h0000;
                            end
                        end
                    end
                end
                default: st_q <= S_IDLE;
            endcase
        end
    end

    // Selection: deactivate write and activate pulse on the pin
    always @(posedge clock_in) begin
        if (reset_in) begin
            selected_q <= 1'b1;
            act_cnt_q  <= 16'h0000;
            pin_prev_q <= 1'b0;
        end else begin
            pin_prev_q <= pin_in && pin_oe_n_out;
            if (pin_in && pin_oe_n_out) begin
                if (act_cnt_q != 16'hffff) begin
                    act_cnt_q <= act_cnt_q + 16'd1;
                end
            end else begin
                act_cnt_q <= 16'h0000;
            end
            if (st_q == S_EXEC && hdr_ok && selected_q &&
                cmd == `CMD_WRITE && data_ok && is_deact &&
                deact_hit && !lock_q) begin
                selected_q <= 1'b0;
            end
            if (pin_prev_q && !(pin_in && pin_oe_n_out) &&
                !selected_q && act_cnt_q >= SELECT_MIN_CYCLES &&
                act_cnt_q <= SELECT_MAX_CYCLES) begin
                selected_q <= 1'b1;
            end
        end
    end

    // Signed fields are stored and returned bit for bit, sign first
endmodule

// [prog_link_defines.vh]
/*
 Constants for the supply-line programming link: bit timing,
 command codes, special register addresses and field sizes.
 Assumes a single 200 MHz clock; times are given in microseconds.
*/
`ifndef PROG_LINK_DEFINES_VH
`define PROG_LINK_DEFINES_VH

// Clock rate and time conversion
`define CLK_MHZ               200
`define US_TO_CYC(t)          ((t) * `CLK_MHZ)

// Bit periods and transition point
`define SUPPLY_BIT_MIN_US     1700
`define SUPPLY_BIT_MAX_US     2000
`define REPLY_BIT_US          3000
`define ONE_POINT_PCT         65

// Programming voltage handshake
`define PROG_DELAY_MAX_US     1000
`define PROG_RISE_MAX_US      1000
`define PROG_HOLD_MIN_US      95000

// Select pulse on the output pin
`define SELECT_MIN_US         50
`define SELECT_MAX_US         200

// Telegram fields
`define HDR_BITS              4'd9
`define REPLY_LONG            5'd16
`define REPLY_ACK             5'd1

// Command codes
`define CMD_READ              3'h2
`define CMD_WRITE             3'h3
`define CMD_BURN              3'h4
`define CMD_ERASE             3'h5
`define CMD_LOCK              3'h7

// Special register addresses and values
`define ADDR_LOCK             4'h6
`define ADDR_ADC              4'h7
`define ADDR_DEACT            4'hf
`define DEACT_VALUE           12'h80f

`endif

// [supply_bit_decoder.v]
/*
 Recovers bits from the supply-line level. The sync bit sets the
 bit period; each later bit is a one when a transition arrives
 inside the bit. Assumes line_in is synchronous to clock_in.
*/
`include "prog_link_defines.vh"

module supply_bit_decoder #(
    parameter [19:0] MIN_CYC = 20'd1,
    parameter [19:0] MAX_CYC = 20'd2
) (
    input  wire        clock_in,
    input  wire        reset_in,
    input  wire        line_in,
    output reg         frame_start_out,
    output reg         bit_valid_out,
    output reg         bit_value_out,
    output reg         frame_end_out
);
    localparam [2:0] D_IDLE = 3'h1;
    localparam [2:0] D_SYNC = 3'h2;
    localparam [2:0] D_BIT  = 3'h4;

    reg  [2:0]  st_q;
    reg         line_q;
    reg         mid_q;
    reg  [19:0] cnt_q;
    reg  [19:0] period_q;
    wire        edge_w  = line_in ^ line_q;
    wire [19:0] len_w   = cnt_q + 20'd1;
    wire [20:0] tout_w  = {1'b0, period_q} + {2'b0, period_q[19:1]};
    wire [19:0] late_w  = period_q - {3'b0, period_q[19:3]};
    wire [19:0] early_w = {2'b0, period_q[19:2]};

    // Sync measurement and bit slicing
    always @(posedge clock_in) begin
        line_q          <= line_in;
        frame_start_out <= 1'b0;
        bit_valid_out   <= 1'b0;
        frame_end_out   <= 1'b0;
        if (reset_in) begin
            st_q          <= D_IDLE;
            mid_q         <= 1'b0;
            cnt_q         <= 20'h00000;
            period_q      <= 20'h00000;
            bit_value_out <= 1'b0;
        end else begin
            case (st_q)
                D_IDLE: begin
                    cnt_q <= 20'h00000;
                    if (edge_w) st_q <= D_SYNC;
                end
                D_SYNC: begin
                    cnt_q <= len_w;
                    if (edge_w) begin
                        cnt_q <= 20'h00000;
                        if (len_w >= MIN_CYC && len_w <= MAX_CYC) begin
                            period_q        <= len_w;
                            st_q            <= D_BIT;
                            mid_q           <= 1'b0;
                            frame_start_out <= 1'b1;
                        end
                    end else if (len_w > MAX_CYC) begin
                        st_q <= D_IDLE;
                    end
                end
                D_BIT: begin
                    cnt_q <= len_w;
                    if (edge_w && !mid_q && len_w < early_w) begin
                        st_q          <= D_IDLE;      // Glitch
                        frame_end_out <= 1'b1;
                    end else if (edge_w && !mid_q && len_w < late_w) begin
                        mid_q <= 1'b1;
                    end else if (edge_w) begin
                        bit_valid_out <= 1'b1;
                        bit_value_out <= mid_q;
                        mid_q         <= 1'b0;
                        cnt_q         <= 20'h00000;
                    end else if ({1'b0, len_w} > tout_w) begin
                        st_q          <= D_IDLE;
                        frame_end_out <= 1'b1;
                    end
                end
                default: st_q <= D_IDLE;
            endcase
        end
    end
endmodule

// [reply_bit_encoder.v]
/*
 Sends a reply on the output pin, first bit from the top of
 bits_in. Every bit ends on a transition; a one adds one inside.
 Assumes start_in is a single-cycle pulse while not busy.
*/
`include "prog_link_defines.vh"

module reply_bit_encoder #(
    parameter [19:0] BIT_CYC = 20'd4
) (
    input  wire        clock_in,
    input  wire        reset_in,
    input  wire        start_in,
    input  wire [4:0]  count_in,
    input  wire [15:0] bits_in,
    output reg         pin_out,
    output reg         oe_n_out,
    output reg         busy_out
);
    localparam [31:0] ONE_PT = BIT_CYC * `ONE_POINT_PCT / 100;

    reg [19:0] cnt_q;
    reg [4:0]  left_q;
    reg [15:0] shift_q;

    // Reply shifter, pin released when idle
    always @(posedge clock_in) begin
        if (reset_in) begin
            pin_out  <= 1'b0;
            oe_n_out <= 1'b1;
            busy_out <= 1'b0;
            cnt_q    <= 20'h00000;
            left_q   <= 5'h00;
            shift_q  <= 16'h0000;
        end else if (!busy_out) begin
            if (start_in) begin
                pin_out  <= 1'b1;        // Opening edge
                oe_n_out <= 1'b0;
                busy_out <= 1'b1;
                cnt_q    <= 20'h00000;
                left_q   <= count_in;
                shift_q  <= bits_in;
            end
        end else begin
            cnt_q <= cnt_q + 20'd1;
            if (cnt_q == ONE_PT[19:0] && shift_q[15]) begin
                pin_out <= ~pin_out;
            end
            if (cnt_q == BIT_CYC - 20'd1) begin
                pin_out <= ~pin_out;
                cnt_q   <= 20'h00000;
                shift_q <= {shift_q[14:0], 1'b0};
                left_q  <= left_q - 5'd1;
                if (left_q == 5'd1) begin
                    busy_out <= 1'b0;
                    oe_n_out <= 1'b1;
                    pin_out  <= 1'b0;
                end
            end
        end
    end
endmodule

// [telegram_checker_properties.sv]
/* Checker of the telegram engine's pin, select and burn ports.
   Assumes the reply bit period of the design. */
module telegram_checker #(
    parameter [19:0] REPLY_BIT_CYCLES = 20'd60
) (
    input wire clock_in,
    input wire reset_in,
    input wire pin_in,
    input wire program_level_in,
    input wire pin_out,
    input wire pin_oe_n_out,
    input wire selected_out,
    input wire analog_mode_out,
    input wire burning_out
);
    timeunit 1ns;
    timeprecision 100ps;
    // Inner toggle is seen one cycle past the 65 percent count
    localparam integer ONE_PT = REPLY_BIT_CYCLES * 65 / 100 + 1;
    reg  [23:0] drv_q;
    wire [23:0] rb = {4'h0, REPLY_BIT_CYCLES};
    wire [23:0] ph = drv_q % rb;
    wire        drv = !pin_oe_n_out;
    // Cycles the pin has been driven so far
    always @(posedge clock_in)
        drv_q <= (reset_in | pin_oe_n_out) ? 24'h0 : drv_q + 24'h1;
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (reset_in);
    property p_ack; drv && drv_q < rb |-> pin_out; endproperty
    a_ack: assert property (p_ack) else $error("ack toggled");
    property p_len;
        $rose(pin_oe_n_out) |-> drv_q == rb || drv_q == 16 * rb; endproperty
    a_len: assert property (p_len) else $error("reply length");
    property p_one; drv && $changed(pin_out) && ph != 0 |-> ph == ONE_PT;
    endproperty
    a_one: assert property (p_one) else $error("inner edge");
    property p_edge; drv && ph == 0 && drv_q != 0 |-> $changed(pin_out);
    endproperty
    a_edge: assert property (p_edge) else $error("no bit edge");
    property p_quiet; !selected_out && $past(!selected_out) |-> !drv;
    endproperty
    a_quiet: assert property (p_quiet) else $error("unselected");
    property p_sel; $rose(selected_out) |-> !$past(pin_in) &&
        ($past(pin_in, 2) || $past(pin_in, 3)); endproperty
    a_sel: assert property (p_sel) else $error("select");
    property p_burn; $rose(burning_out) |-> $past(program_level_in);
    endproperty
    a_burn: assert property (p_burn) else $error("burn");
    property p_lock; analog_mode_out |=> analog_mode_out; endproperty
    a_lock: assert property (p_lock) else $error("unlock");
    property p_busy; burning_out |-> pin_oe_n_out; endproperty
    a_busy: assert property (p_busy) else $error("busy");
    c_sel: cover property ($rose(selected_out));
    c_burn: cover property ($rose(burning_out));
    c_long: cover property ($rose(pin_oe_n_out) && drv_q > rb);
endmodule
bind prog_telegram_top telegram_checker #(
    .REPLY_BIT_CYCLES(REPLY_BIT_CYCLES)) u_chk (.clock_in(clock_in),
    .reset_in(reset_in), .pin_in(pin_in), .pin_out(pin_out),
    .program_level_in(program_level_in), .pin_oe_n_out(pin_oe_n_out),
    .selected_out(selected_out), .analog_mode_out(analog_mode_out),
    .burning_out(burning_out));

// [programmer_model.sv]
/* Programmer model: telegrams on the supply, reply decoding, pulses.
   Assumes the pin is pulled low when nobody drives it. */
module programmer_model #(
    parameter integer L = 36
) (
    input  wire clock_in,
    input  wire pin_in,
    output reg  supply_out = 1'b0,
    output reg  prog_out   = 1'b0,
    output reg  act_out    = 1'b0
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam integer P1 = L * 65 / 100;
    // Waits c edges, then steps off the edge
    task w(input integer c);
        begin
            repeat (c) @(posedge clock_in);
            #1;
        end
    endtask
    // Sync bit, then n bits first to last, each ending on a toggle
    task send(input [23:0] b, input integer n);
        integer i;
        begin
            supply_out <= ~supply_out;
            repeat (L) @(posedge clock_in);
            supply_out <= ~supply_out;
            for (i = 0; i < n; i = i + 1) begin
                repeat (P1) @(posedge clock_in);
                if (b[23 - i]) supply_out <= ~supply_out;
                repeat (L - P1) @(posedge clock_in);
                supply_out <= ~supply_out;
            end
        end
    endtask
    // Times the ack, then decodes n-1 bits at nine tenths of a bit
    task get_reply(input integer n, output [15:0] v, output integer t);
        integer i;
        reg     s;
        begin
            v = 16'h0;
            for (i = 0; i < 200 && pin_in !== 1'b1; i = i + 1) w(1);
            for (t = 0; pin_in === 1'b1 && t < 300; t = t + 1) w(1);
            for (i = 1; i < n && t > 0; i = i + 1) begin
                s = pin_in;
                w(t * 9 / 10);
                v = {v[14:0], pin_in !== s};
                w(t - t * 9 / 10);
            end
        end
    endtask
    // Activate pulse on the pin or programming level on the supply
    task pulse(input integer on_pin, d, h);
        begin
            repeat (d) @(posedge clock_in);
            if (on_pin != 0) act_out <= 1'b1;
            else prog_out <= 1'b1;
            repeat (h) @(posedge clock_in);
            act_out  <= 1'b0;
            prog_out <= 1'b0;
            w(4);
        end
    endtask
endmodule

// [testbench.sv]
/* Self-checking bench of the telegram engine and programmer model.
   Assumes shortened timing parameters. */
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    reg         clock_in, reset_in;
    reg  [13:0] adc_q;
    reg  [3:0]  cfg_a;
    reg  [15:0] v;
    reg  [23:0] e;
    wire [13:0] cfg;
    wire        pin, pin_o, oe_n, sel, ana, burn, sup, prg, act;
    integer     errors = 0, n_compared = 0, t, k;
    // Pulled-low pin: device when enabled, else the programmer
    assign pin = oe_n ? act : pin_o;
    prog_telegram_top #(
        .SYNC_MIN_CYCLES(20'd34), .SYNC_MAX_CYCLES(20'd40),
        .REPLY_BIT_CYCLES(20'd60), .PROG_WAIT_CYCLES(25'd50),
        .PROG_HOLD_MIN_CYCLES(25'd100)
    ) u_dut (
        .clock_in(clock_in), .reset_in(reset_in), .supply_level_in(sup),
        .program_level_in(prg), .pin_in(pin), .adc_value_in(adc_q),
        .cfg_addr_in(cfg_a), .pin_out(pin_o), .pin_oe_n_out(oe_n),
        .selected_out(sel), .analog_mode_out(ana), .burning_out(burn),
        .cfg_data_out(cfg));
    programmer_model u_prog (.clock_in(clock_in), .pin_in(pin),
        .supply_out(sup), .prog_out(prg), .act_out(act));
    // Telegram bits with their parity bits
    function [23:0] tg(input [2:0] c, input [3:0] a, input [13:0] d);
        tg = {c, ^(~c), a, ^(~a), d, ~^(~d)};
    endfunction
    task check(input [31:0] seen, input [31:0] exp, input [63:0] nm);
        begin
            n_compared = n_compared + 1;
            if (seen !== exp) begin
                errors = errors + 1;
                $display("BAD %0s exp %h seen %h", nm, exp, seen);
            end
        end
    endtask
    // Telegram, reply, then the acknowledge length against ta
    task xfer(input [23:0] b, input integer n, r, ta, input [63:0] nm);
        begin
            u_prog.send(b, n);
            u_prog.get_reply(r, v, t);
            check(t, ta, nm);
        end
    endtask
    task s_write_read;
        begin
            xfer(tg(3'h3, 4'hb, 14'h3fe5), 24, 1, 60, "wr ack");
            check(cfg, 14'h0025, "wr val");
            xfer(tg(3'h2, 4'hb, 14'h0), 9, 16, 60, "rd ack");
            e = tg(3'h0, 4'h0, 14'h2500);
            check(v[14:0], e[14:0], "rd tc");
            adc_q <= 14'h2a5c;
            xfer(tg(3'h2, 4'h7, 14'h0), 9, 16, 60, "adc ack");
            e = tg(3'h0, 4'h0, 14'h2a5c);
            check(v[14:0], e[14:0], "rd adc");
        end
    endtask
    task s_refuse;
        begin
            for (k = 0; k < 3; k = k + 1)
                xfer(tg(3'h3, 4'hb, 14'h0011) ^ (24'h1 << (k * 15 -
                    (k / 2) * 10)), 24, 1, 0, "bad par");
            for (k = 3; k < 6; k = k + 1)
                xfer(tg(k == 5 ? 3'h6 : k[2:0] - 3'h3, 4'hb, 14'h0), 9,
                    16, 0, "bad cmd");
            check(cfg, 14'h0025, "kept");
        end
    endtask
    task s_select;
        begin
            xfer(tg(3'h3, 4'hf, 14'h080f), 24, 1, 0, "deact");
            check(sel, 0, "desel");
            xfer(tg(3'h2, 4'hb, 14'h0), 9, 16, 0, "ignored");
            u_prog.pulse(1, 2, 4);
            check(sel, 0, "short");
            u_prog.pulse(1, 2, 20000);
            check(sel, 1, "active");
        end
    endtask
    task s_prog;
        for (k = 4; k < 6; k = k + 1) begin
            xfer(tg(k[2:0], 4'h0, 14'h0), 9, 1, 60, "prog ack");
            fork
                u_prog.pulse(0, 10, 120);
                #300 check(burn, 1, "burning");
            join
            check(burn, 0, "burnt");
        end
    endtask
    task s_lock;
        begin
            xfer(tg(3'h7, 4'h0, 14'h0), 9, 1, 60, "lock");
            check(ana, 1, "analog");
            xfer(tg(3'h3, 4'hb, 14'h0001), 24, 1, 0, "lock wr");
        end
    endtask
    task give_verdict;
        begin
            $display("compared %0d errors %0d", n_compared, errors);
            if (errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
            else $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    initial begin
        clock_in = 1'b0;
        forever #2.5 clock_in = ~clock_in;
    end
    // Reset, then the scenarios in turn
    initial begin
        reset_in = 1'b1;
        adc_q    = 14'h0;
        cfg_a    = 4'hb;
        repeat (16) @(posedge clock_in);
        reset_in <= 1'b0;
        @(posedge clock_in);
        s_write_read;
        s_refuse;
        s_select;
        s_prog;
        s_lock;
        give_verdict;
    end
endmodule
